/* design/ccd_host_sequencer.sv */
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps

module ccd_host_sequencer
  import ccd_host_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared timing to the devices.
  output logic master_clock,
  output logic line_sync,
  // Colour selection for input and transfer multiplexers.
  output logic [1:0] colour_select,
  // Correction coefficients.
  input wire logic coefficient_latch_clock,
  output logic [23:0] coefficient_bus,
  // Line status from the device.
  input wire logic line_end,
  // Configuration serial port.
  output logic cfg_sclk,
  output logic cfg_sdi,
  output logic cfg_cs_n
);

  typedef enum {ST_IDLE, ST_LOAD, ST_GAIN, ST_SETTLE, ST_SYNC, ST_SCAN, ST_NEXT} state_e;

  state_e state;
  logic [31:0] ctrl;
  logic [15:0] timing;
  logic [15:0] outctl;
  logic [15:0] pixels;
  logic [7:0] gain [3];
  logic [23:0] coef_mem [COEF_DEPTH];
  logic [7:0] coef_index;
  logic [7:0] coef_ptr;
  logic [15:0] line_count;
  logic [1:0] colour;
  logic [2:0] byte_idx;
  logic sent;
  logic [15:0] wait_cnt;
  logic [4:0] mclk_div;
  logic ack;
  logic wr_en;
  logic rd_en;
  logic reload;
  logic ser_busy;
  logic ser_done;
  logic ser_start;
  cfg_frame_s frame;
  dev_cfg_s dev_cfg;
  logic [1:0] pin_level;
  logic latch_q;
  logic end_q;
  logic latch_rise;
  logic end_rise;

  // ==========================================================================
  // Address decode, used only by the error answer to reads and writes.
  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      OFS_CTRL, OFS_TIMING, OFS_OUTCTL, OFS_PIXELS, OFS_GAIN_RED, OFS_GAIN_GREEN,
      OFS_GAIN_BLUE, OFS_COEF_INDEX, OFS_COEF_DATA, OFS_STATUS:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // APB handshake: one wait state, then pready with registered data.
  assign pready = ack;
  assign wr_en = psel && penable && ack && pwrite;
  assign rd_en = psel && penable && !ack && !pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ack <= 1'b0;
    else
      ack <= psel && penable && !ack;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !ack)
    begin
      pslverr <= !is_mapped(paddr);
      prdata <= '0;
      if (rd_en)
      begin
        case (paddr)
          OFS_CTRL: prdata <= ctrl;
          OFS_TIMING: prdata <= {16'h0000, timing};
          OFS_OUTCTL: prdata <= {16'h0000, outctl};
          OFS_PIXELS: prdata <= {16'h0000, pixels};
          OFS_GAIN_RED: prdata <= {24'h000000, gain[0]};
          OFS_GAIN_GREEN: prdata <= {24'h000000, gain[1]};
          OFS_GAIN_BLUE: prdata <= {24'h000000, gain[2]};
          OFS_COEF_INDEX: prdata <= {24'h000000, coef_index};
          OFS_COEF_DATA: prdata <= {8'h00, coef_mem[coef_index]};
          OFS_STATUS: prdata <= {line_count, 8'h00, 3'(state), (state != ST_IDLE), 2'b00, colour};
          default: prdata <= '0;
        endcase
      end
    end
    else
      pslverr <= 1'b0;
  end

  // ==========================================================================
  // Control and configuration registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= '0;
      timing <= TIMING_RESET;
      outctl <= OUTCTL_RESET;
      pixels <= PIXELS_RESET;
      gain[0] <= GAIN_RESET;
      gain[1] <= GAIN_RESET;
      gain[2] <= GAIN_RESET;
    end
    else
    begin
      ctrl[CTRL_RELOAD] <= 1'b0;
      if (wr_en)
      begin
        case (paddr)
          OFS_CTRL: ctrl <= {26'h0, pwdata[5:0]};
          OFS_TIMING: timing <= pwdata[15:0];
          OFS_OUTCTL: outctl <= pwdata[15:0];
          OFS_PIXELS: pixels <= pwdata[15:0];
          OFS_GAIN_RED: gain[0] <= pwdata[7:0];
          OFS_GAIN_GREEN: gain[1] <= pwdata[7:0];
          OFS_GAIN_BLUE: gain[2] <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  assign reload = ctrl[CTRL_RELOAD];

  // ==========================================================================
  // Coefficient memory, written through an auto-incrementing index.
  always_ff @(posedge pclk)
  begin
    if (wr_en && paddr == OFS_COEF_DATA)
      coef_mem[coef_index] <= pwdata[23:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      coef_index <= '0;
    else if (wr_en && paddr == OFS_COEF_INDEX)
      coef_index <= pwdata[7:0];
    else if (wr_en && paddr == OFS_COEF_DATA)
      coef_index <= coef_index + 8'd1;
  end

  // ==========================================================================
  // Device configuration image built from the registers.
  always_comb
  begin
    dev_cfg.mode = timing[0];
    dev_cfg.reset_width = timing[2:1];
    dev_cfg.reset_polarity = timing[3];
    dev_cfg.reset_position = timing[7:4];
    dev_cfg.reference_sample_position = timing[11:8];
    dev_cfg.signal_sample_position = timing[15:12];
    dev_cfg.output_enable = outctl[3:0];
    dev_cfg.transfer_width = outctl[5:4];
    dev_cfg.guardband = outctl[7:6];
    dev_cfg.transfer_polarity = outctl[8];
    dev_cfg.signal_polarity = outctl[9];
    dev_cfg.power_down = ctrl[CTRL_POWER_DOWN] && !ctrl[CTRL_RUN];
    dev_cfg.test_bits = 2'b00;
    dev_cfg.pad = 3'b000;
    dev_cfg.dummy_pixels = (pixels[7:0] + 8'd1 < DUMMY_MIN) ? DUMMY_MIN : pixels[7:0] + 8'd1;
    dev_cfg.black_pixels = pixels[15:8];
    dev_cfg.vga_gain = gain[colour];
  end

  // ==========================================================================
  // Pin synchronisers and edge detection.
  pin_sync #(.W(2)) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({line_end, coefficient_latch_clock}),
    .level(pin_level)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_q <= 1'b0;
      end_q <= 1'b0;
    end
    else
    begin
      latch_q <= pin_level[0];
      end_q <= pin_level[1];
    end
  end

  assign latch_rise = pin_level[0] && !latch_q;
  assign end_rise = pin_level[1] && !end_q;

  // ==========================================================================
  // Master clock shared by all devices.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mclk_div <= '0;
      master_clock <= 1'b0;
    end
    else if (mclk_div == 5'(MCLK_HALF - 1))
    begin
      mclk_div <= '0;
      master_clock <= ~master_clock;
    end
    else
      mclk_div <= mclk_div + 5'd1;
  end

  // ==========================================================================
  // Serial configuration writer.
  assign frame = {DEV_CFG_FIRST + 8'(byte_idx), dev_cfg[8 * byte_idx +: 8]};
  assign ser_start = (state == ST_LOAD || state == ST_GAIN) && !sent && !ser_busy;

  cfg_serial_writer u_writer (
    .pclk(pclk),
    .presetn(presetn),
    .start(ser_start),
    .frame(frame),
    .busy(ser_busy),
    .done(ser_done),
    .sclk(cfg_sclk),
    .sdi(cfg_sdi),
    .cs_n(cfg_cs_n)
  );

  // ==========================================================================
  // Line sequencer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      byte_idx <= '0;
      sent <= 1'b0;
      wait_cnt <= '0;
      line_sync <= 1'b0;
    end
    else
    begin
      if (ser_start)
        sent <= 1'b1;
      else if (ser_done)
        sent <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          line_sync <= 1'b0;
          byte_idx <= '0;
          if (ctrl[CTRL_RUN] || reload)
            state <= ST_LOAD;
        end
        ST_LOAD:
        begin
          if (ser_done)
          begin
            if (byte_idx == DEV_CFG_LAST)
            begin
              byte_idx <= DEV_GAIN_BYTE;
              state <= ST_GAIN;
            end
            else
              byte_idx <= byte_idx + 3'd1;
          end
        end
        ST_GAIN:
        begin
          if (ser_done)
          begin
            wait_cnt <= 16'(SETTLE_CYC - 1);
            state <= ctrl[CTRL_RUN] ? ST_SETTLE : ST_IDLE;
          end
        end
        ST_SETTLE:
        begin
          if (wait_cnt == '0)
          begin
            wait_cnt <= 16'(SYNC_CYC - 1);
            line_sync <= 1'b1;
            state <= ST_SYNC;
          end
          else
            wait_cnt <= wait_cnt - 16'd1;
        end
        ST_SYNC:
        begin
          if (wait_cnt == '0)
          begin
            line_sync <= 1'b0;
            state <= ST_SCAN;
          end
          else
            wait_cnt <= wait_cnt - 16'd1;
        end
        ST_SCAN:
        begin
          if (end_rise)
            state <= ST_NEXT;
        end
        ST_NEXT:
        begin
          if (!ctrl[CTRL_RUN])
            state <= ST_IDLE;
          else if (ctrl[CTRL_DEDICATED])
          begin
            wait_cnt <= 16'(SETTLE_CYC - 1);
            state <= ST_SETTLE;
          end
          else
          begin
            byte_idx <= DEV_GAIN_BYTE;
            state <= ST_GAIN;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Colour counter and line count.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      colour <= COLOUR_RED;
      line_count <= '0;
    end
    else if (state == ST_IDLE)
      colour <= ctrl[CTRL_DEDICATED] ? ctrl[CTRL_COLOUR_LSB +: 2] : COLOUR_RED;
    else if (state == ST_NEXT)
    begin
      line_count <= line_count + 16'd1;
      if (!ctrl[CTRL_DEDICATED])
        colour <= (colour == COLOUR_BLUE) ? COLOUR_RED : colour + 2'd1;
    end
  end

  assign colour_select = colour;

  // ==========================================================================
  // Coefficient feed: the next word changes on the third pclk edge after each rising latch edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      coef_ptr <= '0;
      coefficient_bus <= '0;
    end
    else if (state == ST_SYNC)
    begin
      coef_ptr <= 8'd1;
      coefficient_bus <= coef_mem[0];
    end
    else if (state == ST_SCAN && latch_rise)
    begin
      coef_ptr <= coef_ptr + 8'd1;
      coefficient_bus <= coef_mem[coef_ptr];
    end
  end

endmodule

/* include/ccd_host_pkg.sv */
package ccd_host_pkg;

  // ==========================================================================
  // Register map of the controller (APB byte addresses).
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMING = 8'h04;
  localparam logic [7:0] OFS_OUTCTL = 8'h08;
  localparam logic [7:0] OFS_PIXELS = 8'h0C;
  localparam logic [7:0] OFS_GAIN_RED = 8'h10;
  localparam logic [7:0] OFS_GAIN_GREEN = 8'h14;
  localparam logic [7:0] OFS_GAIN_BLUE = 8'h18;
  localparam logic [7:0] OFS_COEF_INDEX = 8'h1C;
  localparam logic [7:0] OFS_COEF_DATA = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // ==========================================================================
  // Field positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DEDICATED = 1;
  localparam int CTRL_COLOUR_LSB = 2;
  localparam int CTRL_RELOAD = 4;
  localparam int CTRL_POWER_DOWN = 5;

  // ==========================================================================
  // Reset values of the configuration registers.
  localparam logic [15:0] TIMING_RESET = 16'h8EA1;
  localparam logic [15:0] OUTCTL_RESET = 16'h020F;
  localparam logic [15:0] PIXELS_RESET = 16'h0501;
  localparam logic [7:0] GAIN_RESET = 8'h00;

  // ==========================================================================
  // Device configuration byte addresses and the minimum dummy pixel count.
  localparam logic [7:0] DEV_CFG_FIRST = 8'h00;
  localparam logic [2:0] DEV_CFG_LAST = 3'd5;
  localparam logic [2:0] DEV_GAIN_BYTE = 3'd6;
  localparam logic [7:0] DUMMY_MIN = 8'h02;

  // ==========================================================================
  // Timing and coefficient memory depth.
  localparam int PCLK_MHZ = 200;
  localparam int MCLK_HALF = 10;
  localparam int SER_HALF = 8;
  localparam int SYNC_NS = 100;
  localparam int SETTLE_NS = 1000;
  localparam int SYNC_CYC = (SYNC_NS * PCLK_MHZ + 999) / 1000;
  localparam int SETTLE_CYC = (SETTLE_NS * PCLK_MHZ + 999) / 1000;
  localparam int COEF_DEPTH = 256;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {COLOUR_RED, COLOUR_GREEN, COLOUR_BLUE} colour_e;

  typedef struct packed {
    logic [7:0] vga_gain;
    logic [7:0] black_pixels;
    logic [7:0] dummy_pixels;
    logic [2:0] pad;
    logic [1:0] test_bits;
    logic power_down;
    logic signal_polarity;
    logic transfer_polarity;
    logic [1:0] guardband;
    logic [1:0] transfer_width;
    logic [3:0] output_enable;
    logic [3:0] signal_sample_position;
    logic [3:0] reference_sample_position;
    logic [3:0] reset_position;
    logic reset_polarity;
    logic [1:0] reset_width;
    logic mode;
  } dev_cfg_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } cfg_frame_s;

endpackage

/* design/pin_sync.sv */
`timescale 1ns/10ps

module pin_sync
  import ccd_host_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pins and synchronised levels.
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  logic [W-1:0] meta;

  // ==========================================================================
  // Two flip-flop synchroniser.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      level <= '0;
    end
    else
    begin
      meta <= pin;
      level <= meta;
    end
  end

endmodule

/* design/cfg_serial_writer.sv */
`timescale 1ns/10ps

module cfg_serial_writer
  import ccd_host_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Request.
  input wire logic start,
  input wire cfg_frame_s frame,
  output logic busy,
  output logic done,
  // Serial pins.
  output logic sclk,
  output logic sdi,
  output logic cs_n
);

  logic [15:0] shreg;
  logic [4:0] bit_cnt;
  logic [3:0] div;
  logic half_en;

  assign half_en = busy && (div == 4'(SER_HALF - 1));

  // ==========================================================================
  // Half-bit divider.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div <= '0;
    else if (!busy || half_en)
      div <= '0;
    else
      div <= div + 4'd1;
  end

  // ==========================================================================
  // Frame shifter, least significant bit first, data sampled on rising sclk.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      sclk <= 1'b0;
      sdi <= 1'b0;
      cs_n <= 1'b1;
      shreg <= '0;
      bit_cnt <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (!busy && start)
      begin
        busy <= 1'b1;
        cs_n <= 1'b0;
        shreg <= {1'b0, frame[15:1]};
        sdi <= frame[0];
        bit_cnt <= '0;
      end
      else if (half_en)
      begin
        sclk <= ~sclk;
        if (sclk)
        begin
          if (bit_cnt == 5'd15)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            cs_n <= 1'b1;
          end
          else
          begin
            sdi <= shreg[0];
            shreg <= {1'b0, shreg[15:1]};
            bit_cnt <= bit_cnt + 5'd1;
          end
        end
      end
    end
  end

endmodule

/* sim/ccd_host_checker.sv */
`timescale 1ns/10ps
// ======================================================================
// Port checker of the sequencer.
module ccd_host_checker
  import ccd_host_pkg::*;
(
  // Clock, reset and bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Device side.
  input wire logic master_clock,
  input wire logic line_sync,
  input wire logic [1:0] colour_select,
  input wire logic cfg_sclk,
  input wire logic cfg_sdi,
  input wire logic cfg_cs_n
);
  logic [7:0] sync_cnt;
  logic [7:0] mc_cnt;
  logic [7:0] gap_cnt;
  logic mc_q;
  logic mc_ok;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_cnt <= 8'h00;
      mc_cnt <= 8'h00;
      gap_cnt <= 8'h00;
      mc_q <= 1'b0;
      mc_ok <= 1'b0;
    end
    else
    begin
      sync_cnt <= line_sync ? sync_cnt + 8'h01 : 8'h00;
      mc_q <= master_clock;
      mc_cnt <= (master_clock == mc_q) ? mc_cnt + 8'h01 : 8'h01;
      mc_ok <= mc_ok | (master_clock != mc_q);
      gap_cnt <= !cfg_cs_n ? 8'h00 : ((gap_cnt == 8'hFF) ? gap_cnt : gap_cnt + 8'h01);
    end
  end
  colour_range_a: assert property (colour_select != 2'h3) else $error("colour out of range");
  colour_hold_a: assert property (line_sync |-> $stable(colour_select)) else $error("colour moved");
  sync_width_a: assert property ($fell(line_sync) |-> sync_cnt == 8'd20) else $error("sync width");
  mclk_half_a: assert property (mc_ok && master_clock != mc_q |-> mc_cnt == 8'd10) else $error("mclk half");
  settle_gap_a: assert property ($rose(line_sync) |-> gap_cnt >= 8'd195) else $error("no settle");
  sclk_frame_a: assert property (cfg_sclk |-> !cfg_cs_n) else $error("sclk outside frame");
  sdi_hold_a: assert property (cfg_sclk |-> $stable(cfg_sdi)) else $error("sdi moved");
  apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("late pready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long pready");
  err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
  cover property ($rose(line_sync));
  cover property (pslverr);
  cover property ($changed(colour_select));
endmodule

bind ccd_host_sequencer ccd_host_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .master_clock(master_clock),
  .line_sync(line_sync), .colour_select(colour_select), .cfg_sclk(cfg_sclk), .cfg_sdi(cfg_sdi),
  .cfg_cs_n(cfg_cs_n));

/* sim/ccd_device_model.sv */
`timescale 1ns/10ps
// ======================================================================
// Behavioural sensor processor: takes config frames, runs lines.
module ccd_device_model
  import ccd_host_pkg::*;
#(
  parameter int NPIX = 4
)
(
  // Line start from the controller.
  input wire logic line_sync,
  // Configuration port.
  input wire logic cfg_sclk,
  input wire logic cfg_sdi,
  input wire logic cfg_cs_n,
  // Line handshake.
  output logic coefficient_latch_clock,
  output logic line_end
);
  logic [7:0] cfg [0:7];
  logic [15:0] sh;
  int nbit;
  int gain_frames;
  int lines;
  initial
  begin
    coefficient_latch_clock = 1'b0;
    line_end = 1'b0;
    nbit = 0;
    gain_frames = 0;
    lines = 0;
  end
  always @(posedge cfg_sclk)
  begin
    if (!cfg_cs_n)
    begin
      sh = {cfg_sdi, sh[15:1]};
      nbit++;
    end
  end
  always @(posedge cfg_cs_n)
  begin
    if (nbit == 16)
    begin
      cfg[sh[10:8]] = sh[7:0];
      if (sh[15:8] == 8'h06)
        gain_frames++;
    end
    nbit = 0;
  end
  // The latch clock runs only within a line and rests low between lines.
  always @(negedge line_sync)
  begin
    if ($time > 0)
    begin
      repeat (NPIX)
      begin
        #62.5 coefficient_latch_clock = 1'b1;
        #62.5 coefficient_latch_clock = 1'b0;
      end
      #100 line_end = 1'b1;
      lines++;
      #200 line_end = 1'b0;
    end
  end
endmodule

/* sim/ccd_host_sequencer_tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; $display("mismatch at %0t: %h not %h", $time, a, b); end end
// ======================================================================
// Bench top.
module ccd_host_sequencer_tb
  import ccd_host_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic master_clock, line_sync, coefficient_latch_clock, line_end, cfg_sclk, cfg_sdi, cfg_cs_n;
  logic [1:0] colour_select;
  logic [23:0] coefficient_bus, cw;
  logic [32:0] e;
  logic [9:0] ln;
  logic [32:0] q_rd[$];
  logic [9:0] q_line[$];
  logic [23:0] q_coef[$];
  logic [7:0] gain[0:2];
  int err_count, cmp_count;

  ccd_host_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clock(master_clock), .line_sync(line_sync), .colour_select(colour_select),
    .coefficient_latch_clock(coefficient_latch_clock), .coefficient_bus(coefficient_bus),
    .line_end(line_end), .cfg_sclk(cfg_sclk), .cfg_sdi(cfg_sdi), .cfg_cs_n(cfg_cs_n));
  ccd_device_model #(.NPIX(4)) i_dev (.line_sync(line_sync), .cfg_sclk(cfg_sclk), .cfg_sdi(cfg_sdi),
    .cfg_cs_n(cfg_cs_n), .coefficient_latch_clock(coefficient_latch_clock), .line_end(line_end));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      err_count++;
      results();
    end
    else
      @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    q_rd.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_lines(input int t);
    int n;
    n = 0;
    while (i_dev.lines < t && n < 20000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20000)
    begin
      err_count++;
      results();
    end
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    i_dev.gain_frames = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // Loads random gains and coefficients, notes what each line must show, then starts.
  task automatic run(input logic [31:0] ctrl, input int nl);
    logic [23:0] coef[0:3];
    logic [1:0] c;
    for (int i = 0; i < 3; i++)
    begin
      gain[i] = 8'($urandom);
      apb(1'b1, OFS_GAIN_RED + 8'(4 * i), {24'h0, gain[i]});
    end
    apb(1'b1, OFS_COEF_INDEX, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      coef[i] = 24'($urandom);
      apb(1'b1, OFS_COEF_DATA, {8'h0, coef[i]});
    end
    for (int l = 0; l < nl; l++)
    begin
      c = ctrl[CTRL_DEDICATED] ? ctrl[3:2] : 2'(l % 3);
      q_line.push_back({c, gain[c]});
      for (int k = 0; k < 4; k++)
        q_coef.push_back(coef[k]);
    end
    apb(1'b1, OFS_CTRL, ctrl);
  endtask

  task automatic chk_cfg(input logic [47:0] img);
    for (int i = 0; i < 6; i++)
      `CHK(i_dev.cfg[i], img[8 * i +: 8])
  endtask

  always @(posedge pclk)
  begin
    if (pready === 1'b1 && psel === 1'b1 && pwrite === 1'b0)
    begin
      e = (q_rd.size() != 0) ? q_rd.pop_front() : 'x;
      `CHK({pslverr, prdata}, e)
    end
  end

  always @(posedge line_sync)
  begin
    ln = (q_line.size() != 0) ? q_line.pop_front() : 'x;
    `CHK(colour_select, ln[9:8])
    `CHK(i_dev.cfg[6], ln[7:0])
  end

  always @(posedge coefficient_latch_clock)
  begin
    cw = (q_coef.size() != 0) ? q_coef.pop_front() : 'x;
    `CHK(coefficient_bus, cw)
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(57));
    do_reset();
    rd(OFS_TIMING, {17'h0, TIMING_RESET});
    rd(OFS_OUTCTL, {17'h0, OUTCTL_RESET});
    rd(OFS_PIXELS, {17'h0, PIXELS_RESET});
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rd(8'h40, {1'b1, 32'h0});
    $display("test registers done");
    apb(1'b1, OFS_TIMING, 32'h8EA9);
    apb(1'b1, OFS_OUTCTL, 32'h030F);
    apb(1'b1, OFS_PIXELS, 32'h0510);
    run(32'h1, 4);
    wait_lines(4);
    chk_cfg(48'h0511_030F_8EA9);
    `CHK(q_line.size(), 0)
    $display("test sequential colour done");
    do_reset();
    for (int i = 0; i < 8; i++)
      i_dev.cfg[i] = 8'h00;
    apb(1'b1, OFS_PIXELS, 32'h0100);
    run(32'h2B, 3);
    wait_lines(7);
    chk_cfg(48'h0102_020F_8EA1);
    `CHK(i_dev.gain_frames, 1)
    `CHK(q_coef.size(), 0)
    rd(OFS_COEF_INDEX, {25'h0, 8'h04});
    $display("test dedicated colour done");
    results();
  end
endmodule
